//--- inc/pasr_pkg.sv
// Shared constants and types for the station address strap and reset block.
package pasr_pkg;

  // Station address strap layout.
  localparam int          ADDR_W             = 5;
  localparam int          ADDR_BIT_LOOPBACK  = 0;
  localparam int          ADDR_BIT_ENCODE    = 1;
  localparam int          ADDR_BIT_CARRIER   = 2;
  localparam int          ADDR_BIT_PLAIN     = 3;
  localparam int          ADDR_BIT_RX_ERROR  = 4;
  localparam logic [4:0]  ISOLATE_ADDR       = 5'h00;
  localparam logic [4:0]  ADDR_RESET_VALUE   = 5'h00;

  // Timing of the strap capture after reset release.
  localparam int          CORE_CLK_PERIOD_NS = 50;
  localparam int          STRAP_SETTLE_NS    = 1000;
  localparam int          STRAP_SETTLE_CYC   = (STRAP_SETTLE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

  // Test port instruction register.
  localparam int          IR_W               = 4;
  localparam logic [3:0]  IR_CAPTURE_VALUE   = 4'h1;
  localparam logic [3:0]  INSTR_IDCODE       = 4'h2;
  localparam logic [3:0]  INSTR_BYPASS       = 4'hf;
  localparam int          IDCODE_W           = 32;
  localparam logic [31:0] IDCODE_DEFAULT     = 32'h0a5a_5001;  // Arbitrary value that names no part.

  typedef enum logic {
    STRAP_SETTLE,
    STRAP_RUN
  } pasr_strap_state_t;

  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } pasr_tap_state_t;

endpackage

//--- logic/pasr_sync.sv
// Two-stage synchroniser for pin levels entering the core clock domain.
`timescale 1ns/10ps
module pasr_sync
  import pasr_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic [WIDTH-1:0] pin_level,
  output logic      [WIDTH-1:0] sync_level
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("pasr_sync: WIDTH must be at least 1");
  end

  // No reset here: these stages only carry pin levels, and resetting them
  // would hide the strap levels while the device reset is held.
  always_ff @(posedge core_clk) begin
    meta_r <= pin_level;
    sync_r <= meta_r;
  end

  assign sync_level = sync_r;

endmodule

//--- logic/pasr_strap.sv
// Strap capture sequencer that latches the station address after reset.
`timescale 1ns/10ps
module pasr_strap
  import pasr_pkg::*;
#(
  parameter int SETTLE_CYC = STRAP_SETTLE_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] strap_level,
  output logic      [ADDR_W-1:0] station_address,
  output logic                   capture_done
);

  localparam int CNT_W = $clog2(SETTLE_CYC + 1);

  pasr_strap_state_t state_r;
  pasr_strap_state_t state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic              done_r;
  logic              done_nxt;

  if (SETTLE_CYC < 3) begin : g_bad_settle
    $error("pasr_strap: SETTLE_CYC must cover the synchroniser delay");
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    done_nxt  = done_r;
    unique case (state_r)
      STRAP_SETTLE: begin
        // The pins are still undriven here, so the address follows the
        // resistor levels and the last sample before the switch is kept.
        addr_nxt = strap_level;
        cnt_nxt  = cnt_r + CNT_W'(1);
        if (cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
          state_nxt = STRAP_RUN;
          done_nxt  = 1'b1;
        end
      end
      STRAP_RUN: begin
        cnt_nxt = cnt_r;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= STRAP_SETTLE;
      cnt_r   <= '0;
      addr_r  <= ADDR_RESET_VALUE;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      done_r  <= done_nxt;
    end
  end

  assign station_address = addr_r;
  assign capture_done    = done_r;

endmodule

//--- logic/pasr_top.sv
// Station address strap capture, dual-function pin handover and test port.
`timescale 1ns/10ps
// Contract
// - Sample strap levels at reset into address
// - Five address bits, one pin per bit
// - All-zero address forces isolation
// - Bit 0 pin becomes loopback enable output
// - Bit 1 pin becomes encode select output
// - Bit 2 pin becomes carrier sense output
// - Bit 4 pin becomes receive error, may float
// - Reset high reinitialises device, recaptures straps
// - Low test reset asynchronously resets test logic
// - Serial data in and out, output may float
// - Test logic clocked by test clock, mode select (here core_clk clocks it, sampling test clock edges)
module pasr_top
  import pasr_pkg::*;
#(
  parameter int          SETTLE_CYC   = STRAP_SETTLE_CYC,
  parameter logic [31:0] IDCODE_VALUE = IDCODE_DEFAULT
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Dual-function pads: level seen on the pad, driven value and enable.
  input  wire logic              loopback_enable_pad,
  output logic                   loopback_enable_out,
  output logic                   loopback_enable_oe,
  input  wire logic              encode_select_pad,
  output logic                   encode_select_out,
  output logic                   encode_select_oe,
  input  wire logic              carrier_sense_pad,
  output logic                   carrier_sense_out,
  output logic                   carrier_sense_oe,
  input  wire logic              station_address_strap3,
  input  wire logic              receive_error_pad,
  output logic                   receive_error_out,
  output logic                   receive_error_oe,
  // Functional values from the rest of the device, same clock.
  input  wire logic              loopback_enable_req,
  input  wire logic              encode_select_req,
  input  wire logic              carrier_sense_req,
  input  wire logic              receive_error_req,
  input  wire logic              receive_error_hiz,
  // Captured address and its consequences.
  output logic      [ADDR_W-1:0] station_address_strap,
  output logic                   station_address_valid,
  output logic                   isolate,
  // Test access port.
  input  wire logic              scan_clock,
  input  wire logic              test_mode_sel,
  input  wire logic              test_data_in,
  input  wire logic              test_reset_n,
  output logic                   test_data_out,
  output logic                   test_data_oe
);

  if (IDCODE_VALUE[0] != 1'b1) begin : g_bad_idcode
    $error("pasr_top: identification value must end in a one");
  end

  // The identification default is arbitrary and names no real part.

  logic [ADDR_W-1:0]   strap_pad;
  logic [ADDR_W-1:0]   strap_sync;
  logic [ADDR_W-1:0]   cap_addr;
  logic                cap_done;

  logic                loopback_r;
  logic                loopback_nxt;
  logic                encode_r;
  logic                encode_nxt;
  logic                crs_r;
  logic                crs_nxt;
  logic                rxer_r;
  logic                rxer_nxt;
  logic                pin_oe_r;
  logic                pin_oe_nxt;
  logic                rxer_oe_r;
  logic                rxer_oe_nxt;
  logic [ADDR_W-1:0]   addr_out_r;
  logic [ADDR_W-1:0]   addr_out_nxt;
  logic                valid_r;
  logic                valid_nxt;
  logic                isolate_r;
  logic                isolate_nxt;

  logic [2:0]          tap_pins;
  logic [2:0]          tap_sync;
  logic                tck_s;
  logic                tms_s;
  logic                tdi_s;
  logic                tck_d_r;
  logic                tck_rise;
  logic                tck_fall;

  pasr_tap_state_t     tap_state_r;
  pasr_tap_state_t     tap_state_nxt;
  logic [IR_W-1:0]     ir_shift_r;
  logic [IR_W-1:0]     ir_shift_nxt;
  logic [IR_W-1:0]     ir_r;
  logic [IR_W-1:0]     ir_nxt;
  logic                bypass_r;
  logic                bypass_nxt;
  logic [IDCODE_W-1:0] id_shift_r;
  logic [IDCODE_W-1:0] id_shift_nxt;
  logic                tdo_r;
  logic                tdo_nxt;
  logic                tdo_oe_r;
  logic                tdo_oe_nxt;

  // Strap pads enter through the synchroniser, one pad per address bit.
  always_comb begin
    strap_pad                    = '0;
    strap_pad[ADDR_BIT_LOOPBACK] = loopback_enable_pad;
    strap_pad[ADDR_BIT_ENCODE]   = encode_select_pad;
    strap_pad[ADDR_BIT_CARRIER]  = carrier_sense_pad;
    strap_pad[ADDR_BIT_PLAIN]    = station_address_strap3;
    strap_pad[ADDR_BIT_RX_ERROR] = receive_error_pad;
  end

  pasr_sync #(
    .WIDTH (ADDR_W)
  ) u_strap_sync (
    .core_clk   (core_clk),
    .pin_level  (strap_pad),
    .sync_level (strap_sync)
  );

  pasr_strap #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_strap (
    .core_clk        (core_clk),
    .reset           (reset),
    .strap_level     (strap_sync),
    .station_address (cap_addr),
    .capture_done    (cap_done)
  );

  // Pin handover: nothing is driven until the address has been taken.
  always_comb begin
    pin_oe_nxt   = cap_done;
    rxer_oe_nxt  = cap_done & ~receive_error_hiz;
    loopback_nxt = cap_done & loopback_enable_req;
    encode_nxt   = cap_done & encode_select_req;
    crs_nxt      = cap_done & carrier_sense_req;
    rxer_nxt     = cap_done & receive_error_req;
    addr_out_nxt = cap_addr;
    valid_nxt    = cap_done;
    // Isolation is also held while capture runs, so the device never
    // answers at an address that is still settling.
    isolate_nxt  = ~cap_done | (cap_addr == ISOLATE_ADDR);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_oe_r   <= 1'b0;
      rxer_oe_r  <= 1'b0;
      loopback_r <= 1'b0;
      encode_r   <= 1'b0;
      crs_r      <= 1'b0;
      rxer_r     <= 1'b0;
      addr_out_r <= ADDR_RESET_VALUE;
      valid_r    <= 1'b0;
      isolate_r  <= 1'b1;
    end else begin
      pin_oe_r   <= pin_oe_nxt;
      rxer_oe_r  <= rxer_oe_nxt;
      loopback_r <= loopback_nxt;
      encode_r   <= encode_nxt;
      crs_r      <= crs_nxt;
      rxer_r     <= rxer_nxt;
      addr_out_r <= addr_out_nxt;
      valid_r    <= valid_nxt;
      isolate_r  <= isolate_nxt;
    end
  end

  assign loopback_enable_out   = loopback_r;
  assign loopback_enable_oe    = pin_oe_r;
  assign encode_select_out     = encode_r;
  assign encode_select_oe      = pin_oe_r;
  assign carrier_sense_out     = crs_r;
  assign carrier_sense_oe      = pin_oe_r;
  assign receive_error_out     = rxer_r;
  assign receive_error_oe      = rxer_oe_r;
  assign station_address_strap = addr_out_r;
  assign station_address_valid = valid_r;
  assign isolate               = isolate_r;

  // The test clock is sampled as a level, so it must stay well below a
  // quarter of the core clock rate for every edge to be seen.
  assign tap_pins = {scan_clock, test_mode_sel, test_data_in};

  pasr_sync #(
    .WIDTH (3)
  ) u_tap_sync (
    .core_clk   (core_clk),
    .pin_level  (tap_pins),
    .sync_level (tap_sync)
  );

  assign tck_s    = tap_sync[2];
  assign tms_s    = tap_sync[1];
  assign tdi_s    = tap_sync[0];
  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  function automatic pasr_tap_state_t tap_next(input pasr_tap_state_t st, input logic tms);
    pasr_tap_state_t nx;
    nx = st;
    unique case (st)
      TAP_RESET:    nx = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:     nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   nx = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nx = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nx = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nx = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR:   nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   nx = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR:   nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nx = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nx = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nx = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR:   nx = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
    return nx;
  endfunction

  // Any code other than the identification one selects the one-bit bypass.
  function automatic logic dr_is_idcode(input logic [IR_W-1:0] ir);
    return ir == INSTR_IDCODE;
  endfunction

  always_comb begin
    tap_state_nxt = tap_state_r;
    ir_shift_nxt  = ir_shift_r;
    ir_nxt        = ir_r;
    bypass_nxt    = bypass_r;
    id_shift_nxt  = id_shift_r;
    tdo_nxt       = tdo_r;
    tdo_oe_nxt    = tdo_oe_r;
    if (tck_rise) begin
      tap_state_nxt = tap_next(tap_state_r, tms_s);
      unique case (tap_state_r)
        TAP_RESET: begin
          ir_nxt = INSTR_IDCODE;
        end
        TAP_CAP_IR: begin
          ir_shift_nxt = IR_CAPTURE_VALUE;
        end
        TAP_SHIFT_IR: begin
          ir_shift_nxt = {tdi_s, ir_shift_r[IR_W-1:1]};
        end
        TAP_UPD_IR: begin
          ir_nxt = ir_shift_r;
        end
        TAP_CAP_DR: begin
          bypass_nxt   = 1'b0;
          id_shift_nxt = IDCODE_VALUE;
        end
        TAP_SHIFT_DR: begin
          if (dr_is_idcode(ir_r)) begin
            id_shift_nxt = {tdi_s, id_shift_r[IDCODE_W-1:1]};
          end else begin
            bypass_nxt = tdi_s;
          end
        end
        default: begin
          ir_nxt = ir_r;
        end
      endcase
    end
    // Data leaves on the falling test clock edge so the far end can take it
    // on the following rising edge with a full half period of margin.
    if (tck_fall) begin
      tdo_oe_nxt = (tap_state_r == TAP_SHIFT_IR) || (tap_state_r == TAP_SHIFT_DR);
      if (tap_state_r == TAP_SHIFT_IR) begin
        tdo_nxt = ir_shift_r[0];
      end else if (dr_is_idcode(ir_r)) begin
        tdo_nxt = id_shift_r[0];
      end else begin
        tdo_nxt = bypass_r;
      end
    end
  end

  // The device reset does not touch the test logic; only the test reset pin
  // or five test clocks with mode select high bring it back.
  always_ff @(posedge core_clk or negedge test_reset_n) begin
    if (!test_reset_n) begin
      tck_d_r     <= 1'b0;
      tap_state_r <= TAP_RESET;
      ir_shift_r  <= IR_CAPTURE_VALUE;
      ir_r        <= INSTR_IDCODE;
      bypass_r    <= 1'b0;
      id_shift_r  <= IDCODE_VALUE;
      tdo_r       <= 1'b0;
      tdo_oe_r    <= 1'b0;
    end else begin
      tck_d_r     <= tck_s;
      tap_state_r <= tap_state_nxt;
      ir_shift_r  <= ir_shift_nxt;
      ir_r        <= ir_nxt;
      bypass_r    <= bypass_nxt;
      id_shift_r  <= id_shift_nxt;
      tdo_r       <= tdo_nxt;
      tdo_oe_r    <= tdo_oe_nxt;
    end
  end

  assign test_data_out = tdo_r;
  assign test_data_oe  = tdo_oe_r;

endmodule

//--- test/pasr_top_chk.sv
// Concurrent checks on strap capture, pin handover and the test data output.
`timescale 1ns/10ps
module pasr_top_chk #(
  parameter int SETTLE_CYC = 20
) (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       loopback_enable_pad,
  input wire logic       loopback_enable_out,
  input wire logic       loopback_enable_oe,
  input wire logic       loopback_enable_req,
  input wire logic       encode_select_pad,
  input wire logic       carrier_sense_pad,
  input wire logic       station_address_strap3,
  input wire logic       receive_error_pad,
  input wire logic       receive_error_out,
  input wire logic       receive_error_oe,
  input wire logic       receive_error_req,
  input wire logic       receive_error_hiz,
  input wire logic [4:0] station_address_strap,
  input wire logic       station_address_valid,
  input wire logic       isolate,
  input wire logic       test_reset_n,
  input wire logic       test_data_out,
  input wire logic       test_data_oe
);
  logic [7:0] since_r;
  logic [7:0] since_nxt;
  // The counter saturates so a long run cannot wrap it back into the capture window.
  always_comb begin
    since_nxt = (since_r == 8'hff) ? since_r : since_r + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    since_r <= reset ? 8'h00 : since_nxt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property ($fell(reset) |-> !loopback_enable_oe && !receive_error_oe
    && !station_address_valid && isolate && station_address_strap == 5'h00) else $error("outputs active after reset");
  a_early_undriven: assert property (!station_address_valid |-> isolate && !loopback_enable_oe
    && !receive_error_oe) else $error("pin driven before capture");
  a_capture_time: assert property (station_address_valid == (since_r > SETTLE_CYC))
    else $error("capture completed at wrong cycle");
  a_capture_value: assert property ($rose(station_address_valid) |-> station_address_strap == $past({
    receive_error_pad, station_address_strap3, carrier_sense_pad, encode_select_pad, loopback_enable_pad}))
    else $error("captured address differs from straps");
  a_isolate_zero: assert property (station_address_valid |-> isolate == (station_address_strap == 5'h00))
    else $error("isolate wrong for address");
  a_address_held: assert property (station_address_valid && $past(station_address_valid)
    |-> $stable(station_address_strap)) else $error("address changed after capture");
  a_pin_follow: assert property (station_address_valid && $past(station_address_valid) |-> loopback_enable_oe
    && loopback_enable_out == $past(loopback_enable_req)) else $error("loopback pin not following request");
  a_rx_error_hiz: assert property (station_address_valid && $past(station_address_valid)
    |-> receive_error_oe == !$past(receive_error_hiz) && receive_error_out == $past(receive_error_req))
    else $error("receive error pin wrong");
  a_tdo_quiet: assert property (!test_reset_n |-> !test_data_oe && !test_data_out)
    else $error("test output active in test reset");
  cover property ($rose(station_address_valid) && !isolate);
  cover property (station_address_valid && isolate);
  cover property ($rose(test_data_oe));
endmodule
bind pasr_top pasr_top_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.core_clk(core_clk), .reset(reset),
  .loopback_enable_pad(loopback_enable_pad), .loopback_enable_out(loopback_enable_out),
  .loopback_enable_oe(loopback_enable_oe), .loopback_enable_req(loopback_enable_req),
  .encode_select_pad(encode_select_pad), .carrier_sense_pad(carrier_sense_pad),
  .station_address_strap3(station_address_strap3), .receive_error_pad(receive_error_pad),
  .receive_error_out(receive_error_out), .receive_error_oe(receive_error_oe),
  .receive_error_req(receive_error_req), .receive_error_hiz(receive_error_hiz),
  .station_address_strap(station_address_strap), .station_address_valid(station_address_valid),
  .isolate(isolate), .test_reset_n(test_reset_n), .test_data_out(test_data_out), .test_data_oe(test_data_oe));

//--- test/pasr_board_model.sv
// Board model: strap resistors on the shared pads and the undriven test data line.
`timescale 1ns/10ps
module pasr_board_model (
  input wire logic [4:0] strap,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic       tdo,
  input wire logic       tdo_oe,
  output logic     [3:0] pad,
  output logic           strap3,
  output logic           tdo_wire
);
  logic tdo_last = 1'b0;
  // A released pad falls back to its resistor, so a late release shows as a wrong capture.
  assign pad = (pin_oe & pin_out) | (~pin_oe & {strap[4], strap[2:0]});
  assign strap3 = strap[3];
  always @(tdo or tdo_oe) begin
    if (tdo_oe) tdo_last = tdo;
  end
  // The test data line has no pull, so a released line shows the opposite of its last value.
  assign tdo_wire = tdo_oe ? tdo : !tdo_last;
endmodule

//--- test/testbench.sv
// Self-checking bench for strap capture, pin handover and the test port.
`timescale 1ns/10ps
module testbench
  import pasr_pkg::*;
;
  localparam int          SETTLE = 3;
  localparam logic [31:0] IDV    = 32'h3c96_e1a5; // Arbitrary identification value.
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [4:0]  strap = 5'h00;
  logic [3:0]  req = 4'h0;
  logic        hiz = 1'b0;
  logic        scan_clock = 1'b0;
  logic        tms = 1'b1;
  logic        tdi = 1'b0;
  logic        trst_n = 1'b0;
  logic [3:0]  pad, out, oe;
  logic [4:0]  addr;
  logic        strap3, valid, isolate, tdo, tdo_oe, tdo_wire;
  logic [16:0] exp_q[$];
  logic [16:0] msk_q[$];
  event        look;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  wire  [16:0] obs = {valid, isolate, addr, oe, out, tdo_wire, tdo_oe};

  pasr_top #(.SETTLE_CYC(SETTLE), .IDCODE_VALUE(IDV)) u_dut (.core_clk(core_clk), .reset(reset),
    .loopback_enable_pad(pad[0]), .loopback_enable_out(out[0]), .loopback_enable_oe(oe[0]),
    .encode_select_pad(pad[1]), .encode_select_out(out[1]), .encode_select_oe(oe[1]),
    .carrier_sense_pad(pad[2]), .carrier_sense_out(out[2]), .carrier_sense_oe(oe[2]),
    .station_address_strap3(strap3), .receive_error_pad(pad[3]), .receive_error_out(out[3]),
    .receive_error_oe(oe[3]), .loopback_enable_req(req[0]), .encode_select_req(req[1]),
    .carrier_sense_req(req[2]), .receive_error_req(req[3]), .receive_error_hiz(hiz),
    .station_address_strap(addr), .station_address_valid(valid), .isolate(isolate),
    .scan_clock(scan_clock), .test_mode_sel(tms), .test_data_in(tdi), .test_reset_n(trst_n),
    .test_data_out(tdo), .test_data_oe(tdo_oe));
  pasr_board_model u_board (.strap(strap), .pin_out(out), .pin_oe(oe), .tdo(tdo), .tdo_oe(tdo_oe),
    .pad(pad), .strap3(strap3), .tdo_wire(tdo_wire));

  always #25 core_clk = ~core_clk;

  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      final_report();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask

  task automatic note(input logic [16:0] e, input logic [16:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    -> look;
  endtask

  // The scan clock is high for ten core cycles and low for at least thirteen, so the two-flop pin sampling never misses an edge.
  task automatic tck(input logic m, input logic d);
    tms = m;
    tdi = d;
    cyc(3);
    scan_clock = 1'b1;
    cyc(10);
    scan_clock = 1'b0;
    cyc(10);
  endtask

  // Walks the controller with the mode select bits taken lowest first.
  task automatic walk(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      tck(m[i], 1'b0);
    end
  endtask

  initial begin : monitor
    logic [16:0] e;
    logic [16:0] m;
    forever begin
      @(look);
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      checked++;
      if ((obs & m) !== (e & m)) begin
        errors++;
        $display("MISMATCH at %0t: got %h expected %h", $time, obs & m, e & m);
      end
    end
  end

  initial begin : main
    logic [4:0] s;
    logic [3:0] r;
    logic       h;
    logic       b;
    void'($urandom(32'h2c10d623));
    for (int k = 0; k < 6; k++) begin
      s = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : 5'($urandom);
      strap = s;
      reset = 1'b1;
      cyc(k == 0 ? 8 : 2);
      trst_n = 1'b1;
      note(17'h08000, 17'h1ffc0);
      reset = 1'b0;
      for (int w = 0; w < 40 && valid !== 1'b1; w++) cyc(1);
      note({1'b1, s == 5'h00, s, 10'h000}, 17'h1fc00);
      strap = ~s;
      cyc(4);
      note({1'b1, s == 5'h00, s, 10'h000}, 17'h1fc00);
    end
    $display("strap capture test done");
    for (int i = 0; i < 24; i++) begin
      r = 4'($urandom);
      h = 1'($urandom);
      req = r;
      hiz = h;
      cyc(1);
      note({7'h00, ~h, 3'h7, r, 2'h0}, 17'h003fc);
    end
    $display("pin handover test done");
    walk(8'h02, 4);
    note({15'h0, IDV[0], 1'b1}, 17'h00003);
    for (int i = 0; i < 32; i++) begin
      tck(i == 31, 1'($urandom));
      if (i < 31) note({15'h0, IDV[i + 1], 1'b1}, 17'h00003);
    end
    note(17'h0, 17'h00001);
    walk(8'h07, 5);
    note({15'h0, IR_CAPTURE_VALUE[0], 1'b1}, 17'h00003);
    for (int i = 0; i < 4; i++) begin
      tck(i == 3, 1'b1);
      if (i < 3) note({15'h0, IR_CAPTURE_VALUE[i + 1], 1'b1}, 17'h00003);
    end
    walk(8'h03, 4);
    note(17'h00001, 17'h00003);
    for (int i = 0; i < 4; i++) begin
      b = 1'($urandom);
      tck(0, b);
      note({15'h0, b, 1'b1}, 17'h00003);
    end
    trst_n = 1'b0;
    cyc(1);
    note(17'h0, 17'h00001);
    trst_n = 1'b1;
    walk(8'h02, 4);
    note({15'h0, IDV[0], 1'b1}, 17'h00003);
    cyc(2);
    $display("test port test done");
    final_report();
  end
endmodule
